// >>> src/lbb_pkg.sv
/*
 * Constants shared by the legacy bus burst bridge: data path codes,
 * buffer limits and legacy strobe timing.
 * Assumes a 250 MHz bridge clock.
 */
package lbb_pkg;

    // ------------------------------------------------------------
    // Legacy data path codes
    // ------------------------------------------------------------
    localparam logic [1:0] W_BYTE  = 2'h0;
    localparam logic [1:0] W_WORD  = 2'h1;
    localparam logic [1:0] W_DWORD = 2'h2;

    // ------------------------------------------------------------
    // Buffer limits
    // ------------------------------------------------------------
    localparam int unsigned WR_LIMIT_BYTES  = 16;
    localparam int unsigned WR_LIMIT_DW     = WR_LIMIT_BYTES / 4;
    localparam int unsigned PREFETCH_MAX_DW = 16;

    // ------------------------------------------------------------
    // Legacy cycle timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned LEG_SETUP_NS   = 8;
    localparam int unsigned LEG_STROBE_NS  = 24;
    localparam int unsigned LEG_RECOVER_NS = 8;
    localparam int unsigned SETUP_CYC   =
        (LEG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC  =
        (LEG_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_CYC =
        (LEG_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] byte_swap(input logic [31:0] d);
        byte_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : byte_swap

endpackage : lbb_pkg

// >>> src/lbb_lane_map.sv
/*
 * Byte lane steering between a buffered little-endian dword and the
 * legacy data bus, for byte, word and dword peripherals.
 * Purely combinational; the caller registers both results.
 */
`timescale 1ns/1ps
module lbb_lane_map
(
    // Write side
    input  wire logic [31:0] wr_dword_i,
    input  wire logic [1:0]  piece_i,
    input  wire logic [1:0]  width_i,
    input  wire logic        big_i,
    // Read side
    input  wire logic [31:0] rd_bus_i,
    input  wire logic [31:0] acc_i,
    // Results
    output logic      [31:0] bus_out_o,
    output logic      [31:0] merged_o
);
    import lbb_pkg::*;

    logic [15:0] wd;
    logic [15:0] rw;

    always_comb
    begin
        bus_out_o = '0;
        merged_o  = acc_i;
        wd        = wr_dword_i[{piece_i[0], 4'h0} +: 16];
        rw        = big_i ? {rd_bus_i[7:0], rd_bus_i[15:8]}
                          : rd_bus_i[15:0];
        case (width_i)
            W_DWORD:
            begin
                bus_out_o = big_i ? byte_swap(wr_dword_i) : wr_dword_i; // R16
                merged_o  = big_i ? byte_swap(rd_bus_i) : rd_bus_i; // R16
            end
            W_WORD:
            begin
                bus_out_o[15:0] = big_i ? {wd[7:0], wd[15:8]} : wd; // R17
                merged_o[{piece_i[0], 4'h0} +: 16] = rw; // R17
            end
            default:
            begin
                // Same lane in both endian modes
                bus_out_o[7:0] = wr_dword_i[{piece_i, 3'h0} +: 8]; // R18
                merged_o[{piece_i, 3'h0} +: 8] = rd_bus_i[7:0]; // R18
            end
        endcase
    end

endmodule : lbb_lane_map

// >>> src/lbb_bridge.sv
/*
 * Delayed-access back end of a PCI target toward a legacy bus:
 * posted write buffer, retried read with prefetch, split/combine
 * and endian steering.
 * Assumes a PCI target front end on the same clock that decodes hits
 * and presents data phases; legacy data in is asynchronous.
 */
`timescale 1ns/1ps
// How it works
// [R1] Single maps to single, burst to burst
// [R2] Chip select held; strobe pulses per transfer
// [R3] Post up to 16 bytes, then disconnect
// [R4] Drain posted data as legacy write burst
// [R5] Delayed-region read answered with retry
// [R6] Prefetch configured length, at most 16 dwords
// [R7] Repeated read served from prefetch buffer
// [R8] Disconnect when prefetched data runs out
// [R9] Leftover prefetched data discarded
// [R10] Peripheral reads must be side-effect free
// [R11] Byte, word and dword peripherals supported
// [R12] Split and combine instead of abort
// [R13] Writes split dword into peripheral-width pieces
// [R14] Byte reads assembled into one dword
// [R15] PCI little endian, optional big endian
// [R16] Dword path: straight or fully swapped lanes
// [R17] Word path: per-halfword lane placement
// [R18] Byte path: always lanes 7:0
// [R19] Retried read latches address, command, enables
// [R20] Active-low select and strobe outputs
// [R21] Width, endian, length are static inputs
// [R22] Disabled byte enables skip write pieces
module lbb_bridge
#(
    parameter int unsigned FIFO_DEPTH = lbb_pkg::PREFETCH_MAX_DW
)
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // PCI target back end
    input  wire logic        PCI_REQ_I,
    input  wire logic        PCI_WRITE_I,
    input  wire logic [31:0] PCI_ADDR_I,
    input  wire logic [3:0]  PCI_CMD_I,
    input  wire logic [3:0]  PCI_BE_I,
    input  wire logic        PCI_DATA_VALID_I,
    input  wire logic        PCI_LAST_I,
    input  wire logic [31:0] PCI_WDATA_I,
    output logic             PCI_ACK_O,
    output logic      [31:0] PCI_RDATA_O,
    output logic             PCI_RETRY_O,
    output logic             PCI_DISCONNECT_O,
    // Static region configuration
    input  wire logic [1:0]  CFG_WIDTH_I,
    input  wire logic        CFG_BIG_ENDIAN_I,
    input  wire logic        CFG_MEM_SPACE_I,
    input  wire logic [4:0]  CFG_BURST_LEN_I,
    // Legacy bus
    output logic      [31:0] LEGACY_ADDR_O,
    output logic             LEGACY_CHIP_SELECT_N_O,
    output logic             LEGACY_IO_READ_N_O,
    output logic             LEGACY_IO_WRITE_N_O,
    output logic             LEGACY_MEM_READ_N_O,
    output logic             LEGACY_MEM_WRITE_N_O,
    input  wire logic [31:0] LEGACY_DATA_BUS_I,
    output logic      [31:0] LEGACY_DATA_BUS_O,
    output logic             LEGACY_DATA_BUS_OE_N_O
);
    import lbb_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_WR_TAKE   = 3'h1,
        ST_LEG_SETUP = 3'h2,
        ST_LEG_STRB  = 3'h3,
        ST_LEG_REC   = 3'h4,
        ST_RD_SERVE  = 3'h5
    } lbb_state_t;

    typedef struct packed {
        lbb_state_t                       state;
        logic [4:0]                       fill;
        logic [4:0]                       blen;
        logic [4:0]                       ridx;
        logic [3:0]                       dw;
        logic [1:0]                       pc;
        logic [2:0]                       tcnt;
        logic                             is_rd;
        logic                             rd_ready;
        logic [31:0]                      acc;
        logic [31:0]                      base;
        logic [3:0]                       cmd;
        logic [3:0]                       be0;
        logic [FIFO_DEPTH-1:0][3:0]       bes;
        logic [FIFO_DEPTH-1:0][31:0]      mem;
        logic                             ack;
        logic [31:0]                      rdata;
        logic                             retry;
        logic                             disc;
        logic [31:0]                      laddr;
        logic                             cs_n;
        logic                             ior_n;
        logic                             iow_n;
        logic                             legacy_mem_read_n_n;
        logic                             legacy_mem_write_n_n;
        logic [31:0]                      ldo;
        logic                             oe_n;
        logic [31:0]                      sync1;
        logic [31:0]                      sync2;
    } lbb_st_t;

    lbb_st_t r;
    lbb_st_t next_r;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] last_piece(input logic [1:0] w);
        case (w)
            W_DWORD: last_piece = 2'h0;
            W_WORD:  last_piece = 2'h1; // R11
            default: last_piece = 2'h3;
        endcase
    endfunction : last_piece

    function automatic logic piece_en(input logic [3:0] be,
                                      input logic [1:0] w,
                                      input logic [1:0] pc);
        case (w)
            W_DWORD: piece_en = |be;
            W_WORD:  piece_en = pc[0] ? |be[3:2] : |be[1:0];
            default: piece_en = be[pc];
        endcase
    endfunction : piece_en

    function automatic logic [4:0] clamp_len(input logic [4:0] l);
        if (l == 5'h0)
            clamp_len = 5'h1;
        else if (l > 5'(FIFO_DEPTH))
            clamp_len = 5'(FIFO_DEPTH);
        else
            clamp_len = l;
    endfunction : clamp_len

    // ------------------------------------------------------------
    // Lane steering
    // ------------------------------------------------------------
    logic [31:0] cur_dw;
    logic [31:0] bus_out;
    logic [31:0] merged;

    assign cur_dw = r.mem[r.dw];

    lbb_lane_map u_lane
    (
        .wr_dword_i (cur_dw),
        .piece_i    (r.pc),
        .width_i    (CFG_WIDTH_I),
        .big_i      (CFG_BIG_ENDIAN_I),
        .rd_bus_i   (r.sync2),
        .acc_i      (r.pc == 2'h0 ? 32'h0 : r.acc),
        .bus_out_o  (bus_out),
        .merged_o   (merged)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [4:0]  total;
    logic [31:0] poff;
    logic        step;
    logic        start_leg;

    always_comb
    begin
        next_r    = r;
        step      = 1'b0;
        start_leg = 1'b0;
        total     = r.is_rd ? r.blen : r.fill;
        poff      = {26'h0, r.dw, 2'h0};
        next_r.ack   = 1'b0;
        next_r.retry = 1'b0;
        next_r.disc  = 1'b0;
        // Legacy data is asynchronous: two stages before use
        next_r.sync1 = LEGACY_DATA_BUS_I;
        next_r.sync2 = r.sync1;
        case (CFG_WIDTH_I)
            W_DWORD: poff = poff;
            W_WORD:  poff = poff + {30'h0, r.pc[0], 1'h0};
            default: poff = poff + {30'h0, r.pc};
        endcase
        case (r.state)
            ST_IDLE:
                if (PCI_REQ_I)
                begin
                    if (PCI_WRITE_I)
                    begin
                        // A write invalidates any prefetched data
                        next_r.state    = ST_WR_TAKE;
                        next_r.base     = PCI_ADDR_I;
                        next_r.cmd      = PCI_CMD_I;
                        next_r.fill     = 5'h0;
                        next_r.is_rd    = 1'b0;
                        next_r.rd_ready = 1'b0;
                    end
                    else if (r.rd_ready && PCI_ADDR_I == r.base
                             && PCI_CMD_I == r.cmd)
                    begin
                        next_r.state = ST_RD_SERVE; // R7
                        next_r.ridx  = 5'h0;
                    end
                    else
                    begin
                        next_r.retry    = 1'b1; // R5
                        next_r.base     = PCI_ADDR_I; // R19
                        next_r.cmd      = PCI_CMD_I; // R19
                        next_r.be0      = PCI_BE_I; // R19
                        next_r.is_rd    = 1'b1;
                        next_r.rd_ready = 1'b0;
                        next_r.fill     = 5'h0;
                        next_r.blen     = clamp_len(CFG_BURST_LEN_I); // R6 R21
                        start_leg       = 1'b1;
                    end
                end
            ST_WR_TAKE:
                if (PCI_DATA_VALID_I)
                begin
                    if (r.fill < 5'(WR_LIMIT_DW))
                    begin
                        next_r.mem[r.fill[3:0]] = PCI_WDATA_I;
                        next_r.bes[r.fill[3:0]] = PCI_BE_I;
                        next_r.fill = r.fill + 5'h1;
                        next_r.ack  = 1'b1;
                        start_leg   = PCI_LAST_I; // R1 R4
                    end
                    else
                    begin
                        next_r.disc = 1'b1; // R3
                        start_leg   = 1'b1; // R4
                    end
                end
            ST_LEG_SETUP:
            begin
                next_r.cs_n  = 1'b0; // R2 R20
                next_r.laddr = r.base + poff;
                if (!r.is_rd && !piece_en(r.bes[r.dw], CFG_WIDTH_I, r.pc))
                    step = 1'b1; // R22
                else
                begin
                    next_r.oe_n = r.is_rd;
                    next_r.ldo  = bus_out; // R13 R15
                    if (r.tcnt == 3'(SETUP_CYC - 1))
                    begin
                        next_r.state  = ST_LEG_STRB;
                        next_r.tcnt   = 3'h0;
                        next_r.ior_n  = !(r.is_rd && !CFG_MEM_SPACE_I);
                        next_r.iow_n  = !(!r.is_rd && !CFG_MEM_SPACE_I);
                        next_r.legacy_mem_read_n_n = !(r.is_rd && CFG_MEM_SPACE_I);
                        next_r.legacy_mem_write_n_n = !(!r.is_rd && CFG_MEM_SPACE_I);
                    end
                    else
                        next_r.tcnt = r.tcnt + 3'h1;
                end
            end
            ST_LEG_STRB:
                if (r.tcnt == 3'(STROBE_CYC - 1))
                begin
                    // One strobe pulse per transfer
                    next_r.ior_n  = 1'b1; // R2
                    next_r.iow_n  = 1'b1;
                    next_r.legacy_mem_read_n_n = 1'b1;
                    next_r.legacy_mem_write_n_n = 1'b1;
                    next_r.state  = ST_LEG_REC;
                    next_r.tcnt   = 3'h0;
                    if (r.is_rd)
                    begin
                        next_r.acc = merged; // R14
                        if (r.pc == last_piece(CFG_WIDTH_I))
                            next_r.mem[r.dw] = merged; // R14
                    end
                end
                else
                    next_r.tcnt = r.tcnt + 3'h1;
            ST_LEG_REC:
                if (r.tcnt == 3'(RECOVER_CYC - 1))
                    step = 1'b1;
                else
                    next_r.tcnt = r.tcnt + 3'h1;
            ST_RD_SERVE:
                if (PCI_DATA_VALID_I)
                begin
                    if (r.ridx < r.fill)
                    begin
                        next_r.rdata = r.mem[r.ridx[3:0]]; // R7
                        next_r.ack   = 1'b1;
                        next_r.ridx  = r.ridx + 5'h1;
                        if (PCI_LAST_I)
                        begin
                            // Remaining prefetch is dropped
                            next_r.rd_ready = 1'b0; // R9
                            next_r.state    = ST_IDLE;
                        end
                    end
                    else
                    begin
                        next_r.disc     = 1'b1; // R8
                        next_r.rd_ready = 1'b0;
                        next_r.state    = ST_IDLE;
                    end
                end
            default:
                next_r.state = ST_IDLE;
        endcase
        if (start_leg)
        begin
            next_r.state = ST_LEG_SETUP;
            next_r.dw    = 4'h0;
            next_r.pc    = 2'h0;
            next_r.tcnt  = 3'h0;
        end
        if (step)
        begin
            // Split/combine: walk pieces, then dwords
            next_r.tcnt  = 3'h0;
            next_r.state = ST_LEG_SETUP;
            if (r.pc != last_piece(CFG_WIDTH_I))
                next_r.pc = r.pc + 2'h1; // R12 R13
            else
            begin
                next_r.pc = 2'h0;
                if ({1'b0, r.dw} == total - 5'h1)
                begin
                    // Select held to the end of the whole burst
                    next_r.cs_n  = 1'b1; // R2
                    next_r.oe_n  = 1'b1;
                    next_r.state = ST_IDLE;
                    if (r.is_rd)
                    begin
                        next_r.rd_ready = 1'b1; // R6
                        next_r.fill     = r.blen;
                    end
                    else
                        next_r.fill = 5'h0;
                end
                else
                    next_r.dw = r.dw + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            r        <= '0;
            r.state  <= ST_IDLE;
            r.cs_n   <= 1'b1;
            r.ior_n  <= 1'b1;
            r.iow_n  <= 1'b1;
            r.legacy_mem_read_n_n <= 1'b1;
            r.legacy_mem_write_n_n <= 1'b1;
            r.oe_n   <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign PCI_ACK_O              = r.ack;
    assign PCI_RDATA_O            = r.rdata;
    assign PCI_RETRY_O            = r.retry;
    assign PCI_DISCONNECT_O       = r.disc;
    assign LEGACY_ADDR_O          = r.laddr;
    assign LEGACY_CHIP_SELECT_N_O = r.cs_n;
    assign LEGACY_IO_READ_N_O     = r.ior_n;
    assign LEGACY_IO_WRITE_N_O    = r.iow_n;
    assign LEGACY_MEM_READ_N_O    = r.legacy_mem_read_n_n;
    assign LEGACY_MEM_WRITE_N_O   = r.legacy_mem_write_n_n;
    assign LEGACY_DATA_BUS_O      = r.ldo;
    assign LEGACY_DATA_BUS_OE_N_O = r.oe_n;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [31:0] head;
    logic        wr_n;
    assign head = r.mem[r.ridx[3:0]];
    assign wr_n = r.iow_n & r.legacy_mem_write_n_n;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_cs_strobe: assert property ( // R2
        !(r.ior_n & r.iow_n & r.legacy_mem_read_n_n & r.legacy_mem_write_n_n) |-> !r.cs_n)
        else $error("strobe active without chip select");
    a_strobe_len: assert property ( // R2
        $fell(wr_n) |-> !wr_n [*6] ##1 wr_n)
        else $error("write strobe pulse has wrong length");
    a_wr_limit: assert property ( // R3
        (r.state == ST_WR_TAKE && PCI_DATA_VALID_I
         && r.fill == 5'(WR_LIMIT_DW)) |=> r.disc && !r.ack)
        else $error("fifth posted dword not disconnected");
    a_drain_start: assert property ( // R4
        (r.state == ST_WR_TAKE && PCI_DATA_VALID_I && PCI_LAST_I
         && r.fill < 5'(WR_LIMIT_DW)) |=> r.state == ST_LEG_SETUP)
        else $error("posted write not drained");
    a_read_retry: assert property ( // R5 R19
        (r.state == ST_IDLE && PCI_REQ_I && !PCI_WRITE_I
         && !r.rd_ready) |=> r.retry && r.be0 == $past(PCI_BE_I)
        && r.base == $past(PCI_ADDR_I) ##1 !r.retry)
        else $error("delayed read not retried");
    a_prefetch_len: assert property ( // R6
        $rose(r.rd_ready) |-> r.fill == r.blen && r.blen <= 5'h10)
        else $error("prefetch length wrong");
    a_serve_data: assert property ( // R7
        (r.state == ST_RD_SERVE && PCI_DATA_VALID_I && r.ridx < r.fill)
        |=> r.ack && r.rdata == $past(head))
        else $error("read data not from prefetch buffer");
    a_disc_empty: assert property ( // R8
        (r.state == ST_RD_SERVE && PCI_DATA_VALID_I
         && r.ridx == r.fill) |=> r.disc && !r.rd_ready)
        else $error("empty prefetch not disconnected");
    a_discard_left: assert property ( // R9
        (r.state == ST_RD_SERVE && PCI_DATA_VALID_I && PCI_LAST_I)
        |=> !r.rd_ready && r.state == ST_IDLE)
        else $error("leftover prefetch kept");
    a_big_dword: assert property ( // R16
        (r.state == ST_LEG_STRB && !r.oe_n && CFG_WIDTH_I == W_DWORD
         && CFG_BIG_ENDIAN_I) |-> r.ldo == byte_swap(cur_dw))
        else $error("big endian dword lanes wrong");
    a_byte_lane: assert property ( // R18
        (r.state == ST_LEG_STRB && !r.oe_n && CFG_WIDTH_I == W_BYTE)
        |-> r.ldo[31:8] == 24'h0)
        else $error("byte path uses upper lanes");

    c_write_drain: cover property (
        r.state == ST_LEG_REC && !r.is_rd ##1 r.state == ST_IDLE);
    c_prefetch: cover property ($rose(r.rd_ready));
    c_served: cover property (r.state == ST_RD_SERVE && r.ack);
    c_disconnect: cover property (r.disc);

endmodule : lbb_bridge

// >>> verification/lbb_legacy_peer.sv
/* Legacy peripheral model: logs write strobes, answers read strobes.
   Assumes it shares the bridge clock. */
`timescale 1ns/1ps
module lbb_legacy_peer
(
    // Legacy side
    input  wire logic        clk_i,
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] data_i,
    output logic      [31:0] data_o
);
    int          n_wr = 0;
    int          n_rd = 0;
    int          n_cs = 0;
    logic [31:0] wlog [0:31];
    logic        pr = 1'b1;
    logic        pw = 1'b1;
    logic        pc = 1'b1;
    logic [31:0] last = '0;
    logic [7:0]  a;
    assign a = addr_i[7:0];
    // Reads are side-effect free; released bus shows the inverse
    assign data_o = rd_n_i ? ~last : {a + 8'h3, a + 8'h2, a + 8'h1, a};
    always @(posedge clk_i)
    begin
        if (pc && !cs_n_i) n_cs++;
        if (!pw && wr_n_i && n_wr < 32)
        begin
            wlog[n_wr] = data_i;
            n_wr++;
        end
        if (!pr && rd_n_i) n_rd++;
        if (!rd_n_i) last = data_o;
        pr = rd_n_i;
        pw = wr_n_i;
        pc = cs_n_i;
    end
endmodule : lbb_legacy_peer

// >>> verification/tb_lbb_bridge.sv
/* Self-checking bench for the legacy bridge.
   Assumes the peer model sits on the legacy side. */
`timescale 1ns/1ps
module tb_lbb_bridge;
    import lbb_pkg::*;
    logic CLK_I = 1'b0, RST_I = 1'b1, rq = 1'b0, wr = 1'b0, valid = 1'b0;
    logic last = 1'b0, big = 1'b0, mem = 1'b0;
    logic [31:0] addr = 32'h40, wdata = 32'h44332211, rdata, ld_o, ld_i, la;
    logic [3:0]  cmd = 4'h0, be = 4'hf;
    logic [1:0]  width = W_DWORD;
    logic [4:0]  blen = 5'h2;
    logic ack, rty, dsc, cs_n, ior, iow, mr, mw, oe_n;
    int n_bad = 0;
    logic [31:0] rd [0:7];
    int n_fail = 0, samples_checked = 0, n_ack = 0, n_retry = 0, n_disc = 0;
    lbb_bridge i_lbb_bridge (.CLK_I(CLK_I), .RST_I(RST_I), .PCI_REQ_I(rq),
        .PCI_WRITE_I(wr), .PCI_ADDR_I(addr), .PCI_CMD_I(cmd), .PCI_BE_I(be),
        .PCI_DATA_VALID_I(valid), .PCI_LAST_I(last), .PCI_WDATA_I(wdata),
        .PCI_ACK_O(ack), .PCI_RDATA_O(rdata), .PCI_RETRY_O(rty),
        .PCI_DISCONNECT_O(dsc), .CFG_WIDTH_I(width), .CFG_BIG_ENDIAN_I(big),
        .CFG_MEM_SPACE_I(mem), .CFG_BURST_LEN_I(blen), .LEGACY_ADDR_O(la),
        .LEGACY_CHIP_SELECT_N_O(cs_n), .LEGACY_IO_READ_N_O(ior),
        .LEGACY_IO_WRITE_N_O(iow), .LEGACY_MEM_READ_N_O(mr),
        .LEGACY_MEM_WRITE_N_O(mw), .LEGACY_DATA_BUS_I(ld_i),
        .LEGACY_DATA_BUS_O(ld_o), .LEGACY_DATA_BUS_OE_N_O(oe_n));
    lbb_legacy_peer i_lbb_legacy_peer (.clk_i(CLK_I), .cs_n_i(cs_n),
        .rd_n_i(ior & mr), .wr_n_i(iow & mw), .addr_i(la), .data_i(ld_o),
        .data_o(ld_i));
    initial forever #2 CLK_I = ~CLK_I;
    always @(posedge CLK_I)
    begin
        if (ack === 1'b1)
        begin
            rd[n_ack % 8] = rdata;
            n_ack++;
        end
        if (rty === 1'b1) n_retry++;
        if (dsc === 1'b1) n_disc++;
        if (mem ? (ior & iow) !== 1'b1 : (mr & mw) !== 1'b1) n_bad++;
        if ((iow & mw) === 1'b0 && oe_n !== 1'b0) n_bad++;
        if ((ior & mr) === 1'b0 && oe_n !== 1'b1) n_bad++;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic clr;
        n_ack = 0;
        n_retry = 0;
        n_disc = 0;
        n_bad = 0;
        i_lbb_legacy_peer.wlog[0] = 'x;
        i_lbb_legacy_peer.n_wr = 0;
        i_lbb_legacy_peer.n_rd = 0;
        i_lbb_legacy_peer.n_cs = 0;
    endtask : clr
    task automatic req_t(input logic w);
        @(posedge CLK_I);
        rq <= 1'b1;
        wr <= w;
        cmd <= w ? 4'h7 : 4'h6;
        @(posedge CLK_I);
        rq <= 1'b0;
    endtask : req_t
    task automatic phases(input int n);
        for (int i = 0; i < n; i++)
        begin
            valid <= 1'b1;
            last <= (i == n - 1);
            be <= (i == 1) ? 4'h5 : 4'hf;
            @(posedge CLK_I);
        end
        valid <= 1'b0;
        last <= 1'b0;
    endtask : phases
    // Bounded waits: a hung burst shows up as a count mismatch
    task automatic wait_burst;
        for (int i = 0; i < 30 && cs_n === 1'b1; i++) @(posedge CLK_I);
        for (int i = 0; i < 400 && cs_n !== 1'b1; i++) @(posedge CLK_I);
        repeat (2) @(posedge CLK_I);
    endtask : wait_burst
    task automatic t_write(input logic [1:0] w, input logic b,
                           input int n, en, input logic [31:0] e);
        logic [31:0] m;
        m = (w == W_DWORD) ? 32'hffffffff :
            (w == W_WORD) ? 32'h0000ffff : 32'h000000ff;
        clr();
        width <= w;
        big <= b;
        mem <= b;
        req_t(1'b1);
        phases(n);
        wait_burst();
        chk("ack", (n > 4) ? 4 : n, n_ack);
        chk("disc", (n > 4) ? 1 : 0, n_disc);
        chk("writes", en, i_lbb_legacy_peer.n_wr);
        chk("cs", 1, i_lbb_legacy_peer.n_cs);
        chk("data", e, i_lbb_legacy_peer.wlog[0] & m);
        chk("strobes", 0, n_bad);
    endtask : t_write
    task automatic t_read;
        clr();
        width <= W_BYTE;
        big <= 1'b0;
        mem <= 1'b1;
        req_t(1'b0);
        wait_burst();
        chk("retry", 1, n_retry);
        chk("reads", 8, i_lbb_legacy_peer.n_rd);
        req_t(1'b0);
        phases(1);
        repeat (2) @(posedge CLK_I);
        chk("rdata0", 32'h43424140, rd[0]);
        req_t(1'b0);
        wait_burst();
        chk("retry2", 2, n_retry);
        req_t(1'b0);
        phases(3);
        repeat (2) @(posedge CLK_I);
        chk("acks", 3, n_ack);
        chk("rdisc", 1, n_disc);
        chk("rdata2", 32'h47464544, rd[2]);
        chk("rstrobes", 0, n_bad);
    endtask : t_read
    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (20) @(posedge CLK_I);
        RST_I <= 1'b0;
        t_write(W_DWORD, 1'b1, 1, 1, 32'h11223344);
        t_write(W_WORD, 1'b1, 1, 2, 32'h00001122);
        t_write(W_WORD, 1'b0, 1, 2, 32'h00002211);
        t_write(W_BYTE, 1'b1, 5, 14, 32'h00000011);
        t_read();
        give_verdict();
    end
    initial
    begin
        #80000;
        n_fail++;
        give_verdict();
    end
endmodule : tb_lbb_bridge
